// File: psm_clk_div.sv
// Core-clock enable divider: one pulse per 2**div_log2 system cycles.
// Assumes div_log2 changes only between pulses or is harmless if not.
`default_nettype none
`include "psm_consts.svh"
module psm_clk_div
  import psm_pkg::*;
(
  input  wire logic sys_clk_i,  // System clock
  input  wire logic reset_i,    // Synchronous reset, high
  psm_clk_if.div    cif         // Control and enable
);
  logic [`PSM_DIV_CNT_W-1:0] cnt;
  wire  [`PSM_DIV_CNT_W-1:0] top_val;
  wire                       at_top;

  assign top_val  = `PSM_DIV_CNT_W'((1 << cif.div_log2) - 1);
  assign at_top   = (cnt >= top_val);
  assign cif.tick = cif.run_en & at_top;

  // Gating the enable instead of the clock keeps one clock domain
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || !cif.run_en || at_top) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + `PSM_DIV_CNT_W'(1);
    end
  end
endmodule : psm_clk_div
`default_nettype wire

// File: psm_clk_if.sv
// Carrier between the controller and its core-clock divider.
// Assumes one system clock shared by both ends.
`default_nettype none
interface psm_clk_if;
  logic       run_en;     // Divider may count
  logic [2:0] div_log2;   // Division as a power of two
  logic       tick;       // One-cycle core-clock enable
  modport ctl (output run_en, output div_log2, input tick);
  modport div (input run_en, input div_log2, output tick);
endinterface : psm_clk_if
`default_nettype wire

// File: psm_consts.svh
// Constants for the power saving mode controller.
// Assumes inclusion by bare name from package and design files.
`ifndef PSM_CONSTS_SVH
`define PSM_CONSTS_SVH

// Register byte addresses on APB
`define PSM_ADDR_MISC      12'h000
`define PSM_ADDR_CLKCTL    12'h004
`define PSM_ADDR_STATUS    12'h008
`define PSM_ADDR_OPTION    12'h00C
// Field positions
`define PSM_MISC_SME_BIT   2
`define PSM_MISC_DIV_LSB   0
`define PSM_CLK_OIE_BIT    0
`define PSM_OPT_WDH_BIT    0
// Reset values
`define PSM_MISC_RST       3'h0
`define PSM_OIE_RST        1'h0
`define PSM_OPT_RST        1'h1
// Timing
`define PSM_WAKE_CPU_CYC   4096
`define PSM_RUN_DIV_LOG2   3'h1
`define PSM_SLOW_DIV_BASE  3'h2
`define PSM_DIV_CNT_W      5

`endif

// File: psm_core_model.sv
// Core model: runs a short service routine after each wake-up.
// Assumes wake_vector_i is a one-cycle pulse on sys_clk_i.
`default_nettype none
module psm_core_model (
  input  wire logic sys_clk_i,     // Clock
  input  wire logic reset_i,       // Reset
  input  wire logic wake_vector_i, // Resume pulse
  output logic      irq_take_o,    // Service entry pulse
  output logic      irq_ret_o      // Flags popped pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] svc_cnt;
  logic [2:0] next_svc;
  // Fixed routine length so the bench can time the pop
  assign next_svc = wake_vector_i ? 3'h5 :
                    (svc_cnt != 3'h0 ? svc_cnt - 3'h1 : 3'h0);
  always_ff @(posedge sys_clk_i) begin
    irq_take_o <= wake_vector_i && !reset_i;
    irq_ret_o  <= svc_cnt == 3'h1 && !reset_i;
    svc_cnt    <= reset_i ? 3'h0 : next_svc;
  end
endmodule : psm_core_model
`default_nettype wire

// File: psm_ctrl.sv
// Power saving mode controller: run, slow, wait, active-halt, halt.
// Assumes an APB master, a core that pulses its sleep instructions and
// samples enables as one-cycle pulses on sys_clk_i.
//
// Contract
// - After reset run at oscillator divided by two.
// - Slow mode enabled: divide by 4, 8, 16 or 32 per select.
// - Slow mode has one enable bit and two divider select bits.
// - Wait while slow keeps the reduced clock for peripherals.
// - Wait stops only the core; peripherals keep their clock.
// - Entering wait clears the interrupt mask bit.
// - Wait ends on any interrupt or reset; core resumes at vector.
// - Service pushes flags, sets mask, pop restores it.
// - Halt goes to full halt if osc irq enable 0, else active-halt.
// - Active-halt keeps only oscillator and real-time counter running.
// - Active-halt exit waits 4096 core cycles before resuming.
// - Entering active-halt clears the interrupt mask bit.
// - Active-halt with osc irq enabled gives no watchdog reset.
// - Full halt stops oscillator and all internal clocks.
// - Full halt exit restarts oscillator, waits 4096 core cycles.
// - Entering full halt forces the interrupt mask bit to zero.
// - Halt with watchdog on resets only if the sleep option says so.
// - Only external sources leave halt; rt counter ends active-halt.
`default_nettype none
`include "psm_consts.svh"
module psm_ctrl
  import psm_pkg::*;
#(
  parameter int WAKE_CYCLES = `PSM_WAKE_CPU_CYC  // Restart delay
)(
  input  wire logic        sys_clk_i,       // System clock (oscillator)
  input  wire logic        reset_i,         // Synchronous reset, high
  input  wire logic        psel,            // APB select
  input  wire logic        penable,         // APB access phase
  input  wire logic        pwrite,          // APB write
  input  wire logic [11:0] paddr,           // APB byte address
  input  wire logic [31:0] pwdata,          // APB write data
  output logic      [31:0] prdata,          // APB read data
  output logic             pready,          // APB ready
  output logic             pslverr,         // APB error
  input  wire logic        wfi_exec_i,      // Wait instruction pulse
  input  wire logic        halt_exec_i,     // Halt instruction pulse
  input  wire logic        irq_any_i,       // Any pending interrupt
  input  wire logic        irq_ext_i,       // Halt-capable interrupt
  input  wire logic        irq_rtc_i,       // Rt counter or clock security
  input  wire logic        irq_take_i,      // Core enters service routine
  input  wire logic        irq_ret_i,       // Core pops flags on return
  input  wire logic        mask_set_i,      // Software sets mask bit
  input  wire logic        mask_clr_i,      // Software clears mask bit
  input  wire logic        wdg_active_i,    // Watchdog running
  output logic             irq_mask_o,      // Condition code mask bit
  output logic             cpu_run_o,       // Core may execute
  output logic             core_tick_o,     // Core clock enable pulse
  output logic             periph_tick_o,   // Peripheral clock enable
  output logic             osc_on_o,        // Main oscillator enable
  output logic             rtc_run_o,       // Rt counter clock enable
  output logic             wake_vector_o,   // Pulse: resume at vector
  output logic             wdg_reset_o,     // Pulse: watchdog reset
  output logic      [2:0]  mode_o           // Current mode code
);
  import psm_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [2:0]  misc_control_one;      // Slow enable and divider select
  logic        osc_irq_enable;
  logic        watchdog_sleep_option;
  logic        irq_mask;
  logic        mask_stack;            // Mask pushed on service entry
  psm_state_t  state;
  psm_state_t  next_state;
  logic [12:0] wake_cnt;
  logic        wake_vec;
  logic        wdg_rst;
  logic [31:0] rd_data;

  wire       slow_mode_enable    = misc_control_one[`PSM_MISC_SME_BIT];
  wire [1:0] slow_divider_select = misc_control_one[1:0];

  ////////////////////////////////////////////////////////////////////////
  // APB decode; answers in the access cycle, no wait states
  wire wr_en    = psel & penable & pwrite;
  wire hit_misc = (paddr == `PSM_ADDR_MISC);
  wire hit_clk  = (paddr == `PSM_ADDR_CLKCTL);
  wire hit_stat = (paddr == `PSM_ADDR_STATUS);
  wire hit_opt  = (paddr == `PSM_ADDR_OPTION);
  wire hit_any  = hit_misc | hit_clk | hit_stat | hit_opt;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  assign rd_data = hit_misc ? {29'h0, misc_control_one} :
                   hit_clk  ? {31'h0, osc_irq_enable} :
                   hit_stat ? {26'h0, irq_mask, cpu_run_o, 1'b0, state} :
                   hit_opt  ? {31'h0, watchdog_sleep_option} : 32'h0;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_data;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      misc_control_one      <= `PSM_MISC_RST;
      osc_irq_enable        <= `PSM_OIE_RST;
      watchdog_sleep_option <= `PSM_OPT_RST;
    end else if (wr_en) begin
      if (hit_misc) misc_control_one <= pwdata[2:0];
      if (hit_clk) osc_irq_enable <= pwdata[`PSM_CLK_OIE_BIT];
      if (hit_opt) watchdog_sleep_option <= pwdata[`PSM_OPT_WDH_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock division
  function automatic logic [2:0] div_log2_of(input logic sme,
                                             input logic [1:0] sel);
    // Select 00..11 maps to divide by 4..32
    div_log2_of = sme ? (`PSM_SLOW_DIV_BASE + {1'b0, sel})
                      : `PSM_RUN_DIV_LOG2;
  endfunction : div_log2_of

  psm_clk_if cif ();

  wire osc_running = (state != PSM_HALT);
  wire periph_on   = (state == PSM_RUN) || (state == PSM_WAIT);

  assign cif.run_en   = osc_running;
  assign cif.div_log2 = div_log2_of(slow_mode_enable, slow_divider_select);

  psm_clk_div u_div (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .cif       (cif)
  );

  // Wait keeps the (possibly slow) rate for peripherals only
  assign core_tick_o   = cif.tick & (state == PSM_RUN);
  assign periph_tick_o = cif.tick & periph_on;
  assign rtc_run_o     = osc_running;
  assign osc_on_o      = osc_running;
  assign cpu_run_o     = (state == PSM_RUN);
  assign mode_o        = state;
  assign irq_mask_o    = irq_mask;
  assign wake_vector_o = wake_vec;
  assign wdg_reset_o   = wdg_rst;

  ////////////////////////////////////////////////////////////////////////
  // Mode sequencing
  wire halt_wake  = irq_ext_i;
  wire ahalt_wake = irq_ext_i | irq_rtc_i;
  wire wake_done  = (wake_cnt == 13'(WAKE_CYCLES - 1)) & cif.tick;

  always_comb begin
    next_state = state;
    case (state)
      PSM_RUN: begin
        if (wfi_exec_i) begin
          next_state = PSM_WAIT;
        end else if (halt_exec_i) begin
          next_state = osc_irq_enable ? PSM_AHALT : PSM_HALT;
        end
      end
      PSM_WAIT:  if (irq_any_i) next_state = PSM_RUN;
      PSM_AHALT: if (ahalt_wake) next_state = PSM_WAKE;
      PSM_HALT:  if (halt_wake) next_state = PSM_WAKE;
      PSM_WAKE:  if (wake_done) next_state = PSM_RUN;
      default:   next_state = PSM_RUN;
    endcase
  end

  // Halt with watchdog on and no osc irq: reset if option selects it
  wire halt_wdg = (state == PSM_RUN) & halt_exec_i & ~wfi_exec_i
                  & ~osc_irq_enable & wdg_active_i
                  & ~watchdog_sleep_option;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state <= PSM_RUN;
    end else if (halt_wdg) begin
      state <= PSM_RUN;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i || state != PSM_WAKE) begin
      wake_cnt <= 13'h0;
    end else if (cif.tick) begin
      wake_cnt <= wake_cnt + 13'h1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      wake_vec <= 1'b0;
      wdg_rst  <= 1'b0;
    end else begin
      wake_vec <= ((state == PSM_WAIT) & irq_any_i)
                | ((state == PSM_WAKE) & wake_done);
      wdg_rst  <= halt_wdg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Condition code mask bit; set by reset so all irqs start disabled
  wire enter_sleep = (state == PSM_RUN) & (wfi_exec_i | halt_exec_i)
                     & ~halt_wdg;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      irq_mask   <= 1'b1;
      mask_stack <= 1'b0;
    end else if (enter_sleep) begin
      irq_mask <= 1'b0;
    end else if (irq_take_i) begin
      mask_stack <= irq_mask;
      irq_mask   <= 1'b1;
    end else if (irq_ret_i) begin
      irq_mask <= mask_stack;
    end else if (mask_set_i) begin
      irq_mask <= 1'b1;
    end else if (mask_clr_i) begin
      irq_mask <= 1'b0;
    end
  end
endmodule : psm_ctrl
`default_nettype wire

// File: psm_ctrl_sva.sv
// Checker for psm_ctrl mode sequencing and clock gating.
// Assumes a bind to psm_ctrl; it sees only that module's ports.
`default_nettype none
module psm_ctrl_sva
  import psm_pkg::*;
#(
  parameter int WAKE_CYCLES = 4  // Restart delay in core ticks
)(
  input wire logic       sys_clk_i,     // Clock
  input wire logic       reset_i,       // Reset
  input wire logic       wfi_exec_i,    // Wait pulse
  input wire logic       halt_exec_i,   // Halt pulse
  input wire logic       irq_any_i,     // Any irq
  input wire logic       irq_ext_i,     // Halt-capable irq
  input wire logic       irq_take_i,    // Service entry
  input wire logic       irq_mask_o,    // Mask bit
  input wire logic       cpu_run_o,     // Core runs
  input wire logic       core_tick_o,   // Core tick
  input wire logic       periph_tick_o, // Peripheral tick
  input wire logic       osc_on_o,      // Oscillator on
  input wire logic       rtc_run_o,     // Rt counter runs
  input wire logic       wake_vector_o, // Resume pulse
  input wire logic       wdg_reset_o,   // Watchdog reset
  input wire logic [2:0] mode_o         // Mode code
);
  timeunit 1ns;
  timeprecision 1ns;
  int wake_cnt;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////////
  // Cycles spent restarting; bounds the delay after either halt
  always_ff @(posedge sys_clk_i) begin
    wake_cnt <= (reset_i || mode_o != PSM_WAKE) ? 0 : wake_cnt + 1;
  end
  property p_cpu_run;
    cpu_run_o == (mode_o == PSM_RUN);
  endproperty
  a_cpu_run: assert property (p_cpu_run)
    else $error("core run flag wrong");
  property p_wait_in;
    mode_o == PSM_RUN && wfi_exec_i |=> mode_o == PSM_WAIT && !irq_mask_o;
  endproperty
  a_wait_in: assert property (p_wait_in)
    else $error("wait entry wrong");
  property p_wait_out;
    mode_o == PSM_WAIT && irq_any_i |=> mode_o == PSM_RUN && wake_vector_o;
  endproperty
  a_wait_out: assert property (p_wait_out)
    else $error("wait exit wrong");
  property p_take;
    irq_take_i && !wfi_exec_i && !halt_exec_i |=> irq_mask_o;
  endproperty
  a_take: assert property (p_take)
    else $error("mask not set on entry");
  property p_sleep_mask;
    $rose(mode_o == PSM_HALT || mode_o == PSM_AHALT) |-> !irq_mask_o;
  endproperty
  a_sleep_mask: assert property (p_sleep_mask)
    else $error("mask set in halt");
  property p_halt_off;
    mode_o == PSM_HALT |-> !osc_on_o && !core_tick_o && !periph_tick_o;
  endproperty
  a_halt_off: assert property (p_halt_off)
    else $error("clock alive in halt");
  property p_ahalt;
    mode_o == PSM_AHALT |-> osc_on_o && rtc_run_o && !periph_tick_o
      && !wdg_reset_o;
  endproperty
  a_ahalt: assert property (p_ahalt)
    else $error("active-halt gating wrong");
  property p_halt_stay;
    mode_o == PSM_HALT && !irq_ext_i |=> mode_o == PSM_HALT;
  endproperty
  a_halt_stay: assert property (p_halt_stay)
    else $error("halt left without source");
  property p_wake_len;
    $fell(mode_o == PSM_WAKE) |-> wake_vector_o
      && wake_cnt >= 2 * WAKE_CYCLES - 1 && wake_cnt <= 2 * WAKE_CYCLES + 1;
  endproperty
  a_wake_len: assert property (p_wake_len)
    else $error("restart delay wrong");
endmodule : psm_ctrl_sva
bind psm_ctrl psm_ctrl_sva #(.WAKE_CYCLES(WAKE_CYCLES)) psm_ctrl_sva_i (
  .sys_clk_i, .reset_i, .wfi_exec_i, .halt_exec_i, .irq_any_i, .irq_ext_i,
  .irq_take_i, .irq_mask_o, .cpu_run_o, .core_tick_o, .periph_tick_o,
  .osc_on_o, .rtc_run_o, .wake_vector_o, .wdg_reset_o, .mode_o);
`default_nettype wire

// File: psm_pkg.sv
// Types of the power saving mode controller.
// Assumes psm_consts.svh on the include path.
`default_nettype none
`include "psm_consts.svh"
package psm_pkg;
  typedef enum logic [2:0] {
    PSM_RUN   = 3'h0,
    PSM_WAIT  = 3'h1,
    PSM_AHALT = 3'h3,
    PSM_HALT  = 3'h2,
    PSM_WAKE  = 3'h6
  } psm_state_t;
endpackage : psm_pkg
`default_nettype wire

// File: tb.sv
// Bench for psm_ctrl: registers, slow rates, wait and both halts.
// Assumes psm_core_model answers wake-ups as the core would.
`default_nettype none
`include "psm_consts.svh"
module tb
  import psm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WC = 4;
  logic sys_clk_i = 0, reset_i = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic wfi_exec_i = 0, halt_exec_i = 0, irq_any_i = 0, irq_ext_i = 0;
  logic irq_rtc_i = 0, wdg_active_i = 0, irq_take_i, irq_ret_i, err;
  logic mask_set_i = 0, mask_clr_i = 0;
  logic pready, pslverr, irq_mask_o, cpu_run_o, core_tick_o, osc_on_o;
  logic periph_tick_o, rtc_run_o, wake_vector_o, wdg_reset_o;
  logic [2:0] mode_o;
  int error_cnt = 0, checked = 0, nc, np, nw, n;
  always #5 sys_clk_i = ~sys_clk_i;
  psm_ctrl #(.WAKE_CYCLES(WC)) psm_ctrl_i (.sys_clk_i, .reset_i, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .wfi_exec_i, .halt_exec_i, .irq_any_i, .irq_ext_i, .irq_rtc_i,
    .irq_take_i, .irq_ret_i, .mask_set_i, .mask_clr_i,
    .wdg_active_i, .irq_mask_o, .cpu_run_o, .core_tick_o, .periph_tick_o,
    .osc_on_o, .rtc_run_o, .wake_vector_o, .wdg_reset_o, .mode_o);
  psm_core_model psm_core_model_i (.sys_clk_i, .reset_i,
    .wake_vector_i(wake_vector_o), .irq_take_o(irq_take_i),
    .irq_ret_o(irq_ret_i));
  ////////////////////////////////////////////////////////////////////
  task wrap_up;
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    for (i = 0; i < 8; i++) begin
      @(posedge sys_clk_i);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(i < 8, 1, "apb timeout");
    if (i == 8) wrap_up();
  endtask : apb
  task cnt(input int k);
    nc = 0;
    np = 0;
    nw = 0;
    repeat (k) begin
      @(posedge sys_clk_i);
      nc += core_tick_o === 1'b1;
      np += periph_tick_o === 1'b1;
      nw += wdg_reset_o === 1'b1;
    end
  endtask : cnt
  // One-cycle pulse: wfi, halt, any, ext, rtc
  task pulse(input int s);
    @(posedge sys_clk_i);
    {irq_rtc_i, irq_ext_i, irq_any_i, halt_exec_i, wfi_exec_i} <= 5'h01 << s;
    @(posedge sys_clk_i);
    {irq_rtc_i, irq_ext_i, irq_any_i, halt_exec_i, wfi_exec_i} <= 5'h00;
    #1;
  endtask : pulse
  task wake(input string m);
    for (n = 0; n < 64; n++) begin
      @(posedge sys_clk_i);
      #1;
      if (mode_o === PSM_RUN) break;
    end
    chk(n >= 2 * WC - 2 && n <= 2 * WC + 1, 1, m);
    chk(wake_vector_o, 1, "no wake vector");
    if (n == 64) wrap_up();
    repeat (8) @(posedge sys_clk_i);
  endtask : wake
  ////////////////////////////////////////////////////////////////////
  task t_reset;
    #1;
    chk({mode_o, irq_mask_o}, {PSM_RUN, 1'b1}, "reset state");
    cnt(16);
    chk(nc, 8, "run rate");
    apb(1'b0, `PSM_ADDR_MISC, 0);
    chk(rd, 0, "misc reset");
    apb(1'b0, `PSM_ADDR_OPTION, 0);
    chk(rd, 1, "option reset");
    apb(1'b0, 12'h010, 0);
    chk(err, 1, "unmapped");
    @(posedge sys_clk_i);
    mask_clr_i <= 1'b1;
    @(posedge sys_clk_i);
    mask_clr_i <= 1'b0;
    #1;
    chk(irq_mask_o, 0, "mask clear");
    @(posedge sys_clk_i);
    mask_set_i <= 1'b1;
    @(posedge sys_clk_i);
    mask_set_i <= 1'b0;
    #1;
    chk(irq_mask_o, 1, "mask set");
  endtask : t_reset
  task t_slow;
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, `PSM_ADDR_MISC, 32'h4 | s);
      cnt(32);
      cnt(64);
      chk(nc, 64 >> (s + 2), "slow rate");
    end
    pulse(0);
    chk({mode_o, irq_mask_o}, {PSM_WAIT, 1'b0}, "wait entry");
    cnt(64);
    chk(np, 2, "slow-wait periph");
    pulse(2);
    chk({mode_o, wake_vector_o}, {PSM_RUN, 1'b1}, "wait exit");
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk(irq_mask_o, 1, "service mask");
    repeat (6) @(posedge sys_clk_i);
    #1;
    chk(irq_mask_o, 0, "pop mask");
    apb(1'b1, `PSM_ADDR_MISC, 0);
  endtask : t_slow
  task t_ahalt;
    apb(1'b1, `PSM_ADDR_CLKCTL, 1);
    wdg_active_i <= 1'b1;
    pulse(1);
    chk({mode_o, irq_mask_o}, {PSM_AHALT, 1'b0}, "ahalt entry");
    chk(osc_on_o & rtc_run_o, 1, "ahalt osc");
    cnt(32);
    chk(np + nw, 0, "ahalt quiet");
    pulse(4);
    wake("ahalt delay");
  endtask : t_ahalt
  task t_halt;
    apb(1'b1, `PSM_ADDR_CLKCTL, 0);
    pulse(1);
    chk({mode_o, irq_mask_o}, {PSM_HALT, 1'b0}, "halt entry");
    chk(osc_on_o | rtc_run_o, 0, "halt osc");
    pulse(4);
    cnt(16);
    chk(mode_o, PSM_HALT, "rtc woke halt");
    chk(nc + np + nw, 0, "halt quiet");
    pulse(3);
    wake("halt delay");
  endtask : t_halt
  task t_wdg;
    apb(1'b1, `PSM_ADDR_OPTION, 0);
    pulse(1);
    chk({mode_o, wdg_reset_o}, {PSM_RUN, 1'b1}, "halt wdg");
  endtask : t_wdg
  initial begin
    repeat (4) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_slow();
    t_ahalt();
    t_halt();
    t_wdg();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
